// ---- src/fpep_pkg.sv ----
// constants, encodings and state types of the flash page erase-program sequencer
// assumes a 100 MHz system clock and special-function register access from the core
package fpep_pkg;

	// special-function register addresses
	localparam logic [7:0] ADDR_CMD_STATUS = 8'he4;
	localparam logic [7:0] ADDR_ADDR_LOW   = 8'he5;
	localparam logic [7:0] ADDR_ADDR_HIGH  = 8'he6;
	localparam logic [7:0] ADDR_WRITE_DATA = 8'he7;

	// command bytes and write-enable key
	localparam logic [7:0] CMD_LOAD          = 8'h00;
	localparam logic [7:0] CMD_ERASE_PROGRAM = 8'h68;
	localparam logic [7:0] CMD_SET_WE        = 8'h08;
	localparam logic [7:0] CMD_CLR_WE        = 8'h0b;
	localparam logic [7:0] WE_KEY            = 8'h96;

	// status field positions and reset values
	localparam int         OI_BIT       = 0;
	localparam int         SV_BIT       = 1;
	localparam int         HVE_BIT      = 2;
	localparam int         HVA_BIT      = 3;
	localparam logic [3:0] STATUS_RESET = 4'h0;
	localparam logic [7:0] ADDR_RESET   = 8'h00;
	localparam logic [3:0] STATUS_OI    = 4'h1;
	localparam logic [3:0] STATUS_SV    = 4'h2;
	localparam logic [3:0] STATUS_HVE   = 4'h4;
	localparam logic [3:0] STATUS_HVA   = 4'h8;

	// page buffer geometry
	localparam int         PAGE_BYTES = 16;
	localparam int         IDX_W      = 4;
	localparam logic [3:0] IDX_LAST   = 4'hf;

	// cycle timing: two phases of equal length
	localparam int CLK_MHZ          = 100;
	localparam int ERASE_TIME_US    = 2000;
	localparam int PROGRAM_TIME_US  = 2000;
	localparam int ERASE_CYCLES_DEF = ERASE_TIME_US * CLK_MHZ;
	localparam int PROG_CYCLES_DEF  = PROGRAM_TIME_US * CLK_MHZ;
	localparam int CNT_W            = 18;

	// sequencer states
	typedef enum logic [1:0] {
		ST_IDLE,
		ST_ERASE,
		ST_PROGRAM
	} fpep_state_e;

	// pending write-enable key action
	typedef enum logic [1:0] {
		KEY_NONE,
		KEY_SET,
		KEY_CLR
	} fpep_key_e;

endpackage

// ---- src/fpep_page_buffer.sv ----
// sixteen-byte page buffer with registered read data and one-cycle clear
// assumes write, clear and read index come from logic on the same clock
`timescale 1ns/1ps
`default_nettype none
module fpep_page_buffer (
	input  wire logic       clk,
	input  wire logic       rstn,
	input  wire logic       clear,
	input  wire logic       wrEn,
	input  wire logic [3:0] wrIdx,
	input  wire logic [7:0] wrData,
	input  wire logic [3:0] rdIdx,
	output logic      [7:0] rdData
);

	typedef struct packed {
		logic [fpep_pkg::PAGE_BYTES-1:0][7:0] bytes;
		logic [7:0]                           rdData;
	} fpep_buf_s;

	fpep_buf_s r_q;
	fpep_buf_s r_d;

	// clear wins over a write in the same cycle
	always_comb begin
		r_d = r_q;
		r_d.rdData = r_q.bytes[rdIdx];
		if (clear) begin
			r_d.bytes = '0;
		end else if (wrEn) begin
			r_d.bytes[wrIdx] = wrData;
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			r_q <= '0;
		end else begin
			r_q <= r_d;
		end
	end

	assign rdData = r_q.rdData;

endmodule // fpep_page_buffer
`default_nettype wire

// ---- src/fpep_sequencer.sv ----
// flash page erase-program sequencer: command/status, address and data registers,
// page buffer update flags, timed erase and program phases and processor stall
// assumes the core does one register access per cycle and a byte-wide flash array
// whose read data follow the address combinationally
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - reads of the command register give status, writes take a command byte
// - every command write clears the four status flags
// - page buffer of sixteen bytes, each with its own loaded flag
// - load command 00H clears all buffer bytes and loaded flags
// - data write stores at low-address index and marks that byte loaded
// - low index increments after data write, wraps, upper nibble untouched
// - high address and upper low nibble select the target page
// - only loaded bytes of the page are erased and programmed
// - command 68H starts the cycle and stalls the processor until done
// - interrupt during a cycle aborts it, releases core, sets aborted flag
// - cycle lasts a fixed 2 ms erase plus 2 ms program
// - aborted flag set on abort by interrupt or reset request
// - security flag set when a secured page is targeted
// - high-voltage error flag set on generator fault
// - high-voltage abort flag on interrupt or brownout; bits 7..4 read zero
// - code memory readable through the code read port only while no cycle runs
// - erase and program blocked while flash brownout is reported
// - write enable set by 08H, cleared by 0BH, each with key 96H
module fpep_sequencer #(
	parameter int ERASE_CYCLES   = fpep_pkg::ERASE_CYCLES_DEF,
	parameter int PROGRAM_CYCLES = fpep_pkg::PROG_CYCLES_DEF
) (
	input  wire logic        clk,
	input  wire logic        rstn,
	input  wire logic [7:0]  sfrAddr,
	input  wire logic        sfrWrEn,
	input  wire logic        sfrRdEn,
	input  wire logic [7:0]  sfrWdata,
	output logic      [7:0]  sfrRdata,
	output logic             cpuStall,
	input  wire logic        irqPending,
	input  wire logic        sysResetReq,
	input  wire logic        flashBrownout,
	input  wire logic        hvError,
	input  wire logic        activateWriteEnable,
	input  wire logic        targetSecured,
	output logic      [11:0] pageSelect,
	output logic      [15:0] nvmAddr,
	output logic      [7:0]  nvmWdata,
	output logic             nvmErase,
	output logic             nvmProgram,
	input  wire logic [7:0]  nvmRdata,
	input  wire logic        codeRdEn,
	input  wire logic [15:0] codeRdAddr,
	output logic      [7:0]  codeRdData
);

	typedef struct packed {
		fpep_pkg::fpep_state_e         state;
		logic [fpep_pkg::CNT_W-1:0]    cnt;
		logic [3:0]                    walkIdx;
		logic                          walking;
		logic [3:0]                    rdIdx;
		logic                          rdValid;
		logic [fpep_pkg::PAGE_BYTES-1:0] flags;
		logic [3:0]                    status;
		logic [7:0]                    adrLow;
		logic [7:0]                    adrHigh;
		logic                          weFlag;
		fpep_pkg::fpep_key_e           keyPend;
		logic                          bodMeta;
		logic                          bodSync;
		logic                          stall;
		logic [7:0]                    sfrRdata;
		logic [15:0]                   nvmAddr;
		logic [7:0]                    nvmWdata;
		logic                          nvmErase;
		logic                          nvmProgram;
		logic                          codeRdPend;
		logic [7:0]                    codeRdData;
	} fpep_seq_s;

	fpep_seq_s r_q;
	fpep_seq_s r_d;

	logic       idle;
	logic       wrCmd;
	logic       wrData;
	logic       loadCmd;
	logic       epCmd;
	logic       writeAllowed;
	logic       memClear;
	logic       memWr;
	logic [7:0] memRdata;
	logic [3:0] setBits;
	logic       abortAny;

	// register access decode; writes are taken only while no cycle runs
	assign idle         = (r_q.state == fpep_pkg::ST_IDLE);
	assign wrCmd        = idle && sfrWrEn && (sfrAddr == fpep_pkg::ADDR_CMD_STATUS);
	assign wrData       = idle && sfrWrEn && (sfrAddr == fpep_pkg::ADDR_WRITE_DATA);
	assign loadCmd      = wrCmd && (sfrWdata == fpep_pkg::CMD_LOAD);
	assign epCmd        = wrCmd && (sfrWdata == fpep_pkg::CMD_ERASE_PROGRAM);
	assign writeAllowed = !activateWriteEnable || r_q.weFlag;
	assign memClear     = loadCmd || sysResetReq;
	// key bytes never reach the buffer
	assign memWr        = wrData && (r_q.keyPend == fpep_pkg::KEY_NONE) && !sysResetReq;
	assign abortAny     = !idle && (irqPending || sysResetReq || r_q.bodSync || hvError);

	fpep_page_buffer u_buf (
		.clk    (clk),
		.rstn   (rstn),
		.clear  (memClear),
		.wrEn   (memWr),
		.wrIdx  (r_q.adrLow[3:0]),
		.wrData (sfrWdata),
		.rdIdx  (r_q.walkIdx),
		.rdData (memRdata)
	);

	// next-state logic of the whole sequencer
	always_comb begin
		r_d = r_q;
		setBits = 4'h0;
		r_d.nvmErase = 1'b0;
		r_d.nvmProgram = 1'b0;
		r_d.rdValid = 1'b0;
		r_d.codeRdPend = 1'b0;
		r_d.bodMeta = flashBrownout;
		r_d.bodSync = r_q.bodMeta;
		if (sfrRdEn) begin
			unique case (sfrAddr)
				fpep_pkg::ADDR_CMD_STATUS: r_d.sfrRdata = {4'h0, r_q.status};
				fpep_pkg::ADDR_ADDR_LOW:   r_d.sfrRdata = r_q.adrLow;
				fpep_pkg::ADDR_ADDR_HIGH:  r_d.sfrRdata = r_q.adrHigh;
				default:                   r_d.sfrRdata = 8'h00;
			endcase
		end
		if (idle && sfrWrEn && (sfrAddr == fpep_pkg::ADDR_ADDR_LOW)) begin
			r_d.adrLow = sfrWdata;
		end
		if (idle && sfrWrEn && (sfrAddr == fpep_pkg::ADDR_ADDR_HIGH)) begin
			r_d.adrHigh = sfrWdata;
		end
		if (wrData && (r_q.keyPend != fpep_pkg::KEY_NONE)) begin
			if (sfrWdata == fpep_pkg::WE_KEY) begin
				r_d.weFlag = (r_q.keyPend == fpep_pkg::KEY_SET);
			end
			r_d.keyPend = fpep_pkg::KEY_NONE;
		end
		if (memWr) begin
			r_d.flags[r_q.adrLow[3:0]] = 1'b1;
			r_d.adrLow = {r_q.adrLow[7:4], r_q.adrLow[3:0] + 4'h1};
		end
		if (wrCmd) begin
			r_d.keyPend = fpep_pkg::KEY_NONE;
			if (sfrWdata == fpep_pkg::CMD_SET_WE) begin
				r_d.keyPend = fpep_pkg::KEY_SET;
			end
			if (sfrWdata == fpep_pkg::CMD_CLR_WE) begin
				r_d.keyPend = fpep_pkg::KEY_CLR;
			end
			if (loadCmd) begin
				r_d.flags = '0;
			end
		end
		if (epCmd) begin
			if (r_q.bodSync) begin
				setBits = fpep_pkg::STATUS_HVA;
			end else if (targetSecured || !writeAllowed) begin
				setBits = fpep_pkg::STATUS_SV;
			end else begin
				r_d.state = fpep_pkg::ST_ERASE;
				r_d.cnt = '0;
				r_d.walkIdx = 4'h0;
				r_d.walking = 1'b1;
				r_d.stall = 1'b1;
			end
		end
		if (idle && codeRdEn) begin
			r_d.nvmAddr = codeRdAddr;
			r_d.codeRdPend = 1'b1;
		end
		if (r_q.codeRdPend) begin
			r_d.codeRdData = nvmRdata;
		end
		// byte walk of each phase
		if (!idle && r_q.walking) begin
			r_d.walkIdx = r_q.walkIdx + 4'h1;
			r_d.walking = (r_q.walkIdx != fpep_pkg::IDX_LAST);
			r_d.rdIdx = r_q.walkIdx;
			r_d.rdValid = (r_q.state == fpep_pkg::ST_PROGRAM);
			if (r_q.state == fpep_pkg::ST_ERASE) begin
				r_d.nvmErase = r_q.flags[r_q.walkIdx];
				r_d.nvmAddr = {r_q.adrHigh, r_q.adrLow[7:4], r_q.walkIdx};
			end
		end
		if (r_q.rdValid) begin
			r_d.nvmProgram = r_q.flags[r_q.rdIdx];
			r_d.nvmAddr = {r_q.adrHigh, r_q.adrLow[7:4], r_q.rdIdx};
			r_d.nvmWdata = memRdata;
		end
		unique case (r_q.state)
			fpep_pkg::ST_IDLE: begin
				r_d.cnt = '0;
			end
			fpep_pkg::ST_ERASE: begin
				r_d.cnt = r_q.cnt + 18'h1;
				if (r_q.cnt == fpep_pkg::CNT_W'(ERASE_CYCLES - 1)) begin
					r_d.state = fpep_pkg::ST_PROGRAM;
					r_d.cnt = '0;
					r_d.walkIdx = 4'h0;
					r_d.walking = 1'b1;
				end
			end
			fpep_pkg::ST_PROGRAM: begin
				r_d.cnt = r_q.cnt + 18'h1;
				if (r_q.cnt == fpep_pkg::CNT_W'(PROGRAM_CYCLES - 1)) begin
					r_d.state = fpep_pkg::ST_IDLE;
					r_d.stall = 1'b0;
					r_d.walking = 1'b0;
				end
			end
			// unused state code falls back to idle
			default: begin
				r_d.state = fpep_pkg::ST_IDLE;
			end
		endcase
		if (abortAny) begin
			r_d.state = fpep_pkg::ST_IDLE;
			r_d.stall = 1'b0;
			r_d.walking = 1'b0;
			r_d.rdValid = 1'b0;
			r_d.nvmErase = 1'b0;
			r_d.nvmProgram = 1'b0;
			if (irqPending || sysResetReq) begin
				setBits = setBits | fpep_pkg::STATUS_OI;
			end
			// interrupt or brownout in a cycle
			if (irqPending || r_q.bodSync) begin
				setBits = setBits | fpep_pkg::STATUS_HVA;
			end
			if (hvError) begin
				setBits = setBits | fpep_pkg::STATUS_HVE;
			end
		end
		// reset request empties buffer and protection
		if (sysResetReq) begin
			r_d.flags = '0;
			r_d.weFlag = 1'b0;
			r_d.keyPend = fpep_pkg::KEY_NONE;
		end
		// command write clears status, a same-cycle set still lands
		r_d.status = (wrCmd ? fpep_pkg::STATUS_RESET : r_q.status) | setBits;
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			r_q <= '0;
		end else begin
			r_q <= r_d;
		end
	end

	assign sfrRdata   = r_q.sfrRdata;
	assign cpuStall   = r_q.stall;
	assign pageSelect = {r_q.adrHigh, r_q.adrLow[7:4]};
	assign nvmAddr    = r_q.nvmAddr;
	assign nvmWdata   = r_q.nvmWdata;
	assign nvmErase   = r_q.nvmErase;
	assign nvmProgram = r_q.nvmProgram;
	assign codeRdData = r_q.codeRdData;

	// stall length of an undisturbed cycle, read only by an assertion
	logic [19:0] stallLen_q;
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			stallLen_q <= 20'h00000;
		end else begin
			stallLen_q <= r_q.stall ? stallLen_q + 20'h00001 : 20'h00000;
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);

	status_read_a: assert property (sfrRdEn && sfrAddr == fpep_pkg::ADDR_CMD_STATUS
		|=> sfrRdata == {4'h0, $past(r_q.status)}) else $error("status read wrong");
	cmd_clears_a: assert property (wrCmd && !epCmd && !abortAny
		|=> r_q.status == 4'h0) else $error("command did not clear status");
	load_clear_a: assert property (loadCmd && !sysResetReq
		|=> r_q.flags == '0) else $error("load left flags set");
	data_mark_a: assert property (memWr
		|=> r_q.flags[$past(r_q.adrLow[3:0])]) else $error("loaded flag not set");
	index_wrap_a: assert property (memWr && !(idle && sfrWrEn && sfrAddr == fpep_pkg::ADDR_ADDR_LOW)
		|=> r_q.adrLow == {$past(r_q.adrLow[7:4]), $past(r_q.adrLow[3:0]) + 4'h1})
		else $error("index increment wrong");
	erase_flagged_a: assert property (nvmErase
		|-> r_q.flags[nvmAddr[3:0]] && nvmAddr[15:4] == pageSelect) else $error("erase unloaded byte");
	ep_start_a: assert property (epCmd && !r_q.bodSync && !targetSecured && writeAllowed
		|=> cpuStall && r_q.state == fpep_pkg::ST_ERASE) else $error("cycle did not start");
	irq_abort_a: assert property (!idle && irqPending
		|=> !cpuStall ##0 r_q.status[fpep_pkg::OI_BIT] && r_q.status[fpep_pkg::HVA_BIT])
		else $error("interrupt did not abort");
	full_cycle_a: assert property ($fell(cpuStall) && r_q.status == 4'h0
		|-> $past(stallLen_q) == 20'(ERASE_CYCLES + PROGRAM_CYCLES - 1))
		else $error("cycle length wrong");
	secure_refuse_a: assert property (epCmd && !r_q.bodSync && targetSecured
		|=> !cpuStall[*2] ##0 r_q.status[fpep_pkg::SV_BIT]) else $error("secured page not refused");
	brownout_block_a: assert property (epCmd && r_q.bodSync
		|=> !cpuStall && !nvmErase && r_q.status[fpep_pkg::HVA_BIT]) else $error("brownout did not block");
	we_key_a: assert property (wrData && r_q.keyPend == fpep_pkg::KEY_SET
		&& sfrWdata == fpep_pkg::WE_KEY && !sysResetReq |=> r_q.weFlag) else $error("key did not set enable");
	hv_fault_a: assert property (!idle && hvError
		|=> r_q.status[fpep_pkg::HVE_BIT] && idle) else $error("fault not reported");

	full_cycle_c: cover property ($fell(cpuStall) && r_q.status == 4'h0);
	irq_abort_c: cover property (!idle && irqPending);
	program_byte_c: cover property (nvmProgram);
	secure_refuse_c: cover property (epCmd && targetSecured);

endmodule // fpep_sequencer
`default_nettype wire

// ---- dv/fpep_flash_model.sv ----
// byte-wide flash array model standing behind the sequencer's array port
// assumes erase and program pulses come from registers on the same clock
`timescale 1ns/1ps
`default_nettype none
module fpep_flash_model #(
	parameter logic [7:0] ERASED = 8'hff
) (
	input  wire logic        clk,
	input  wire logic [15:0] nvmAddr,
	input  wire logic [7:0]  nvmWdata,
	input  wire logic        nvmErase,
	input  wire logic        nvmProgram,
	output logic      [7:0]  nvmRdata
);
	logic [7:0] mem [0:65535];

	// known start pattern so that untouched bytes can be told apart
	initial begin
		for (int i = 0; i < 65536; i++) begin
			mem[i] = i[7:0] ^ 8'h5a;
		end
	end

	// erase sets every bit, programming can only clear bits
	always @(posedge clk) begin
		if (nvmErase) begin
			mem[nvmAddr] <= ERASED;
		end
		if (nvmProgram) begin
			mem[nvmAddr] <= mem[nvmAddr] & nvmWdata;
		end
	end

	// read data follow the address without a clock
	assign nvmRdata = mem[nvmAddr];
endmodule // fpep_flash_model
`default_nettype wire

// ---- dv/flash_page_erase_program_tb_top.sv ----
// self-checking bench for the flash page erase-program sequencer
// assumes the array model fpep_flash_model on the array port
`timescale 1ns/1ps
`default_nettype none
module flash_page_erase_program_tb_top;
	localparam int CYC = 32;
	logic        clk, rstn, sfrWrEn, sfrRdEn, cpuStall, irqPending, sysResetReq;
	logic        flashBrownout, hvError, activateWriteEnable, targetSecured;
	logic        nvmErase, nvmProgram, codeRdEn;
	logic [7:0]  sfrAddr, sfrWdata, sfrRdata, nvmWdata, nvmRdata, codeRdData, d;
	logic [11:0] pageSelect;
	logic [15:0] nvmAddr, codeRdAddr;
	int          errorCnt, nChecks, n;

	fpep_sequencer #(.ERASE_CYCLES(CYC), .PROGRAM_CYCLES(CYC)) DUT (.clk(clk), .rstn(rstn),
		.sfrAddr(sfrAddr), .sfrWrEn(sfrWrEn), .sfrRdEn(sfrRdEn), .sfrWdata(sfrWdata),
		.sfrRdata(sfrRdata), .cpuStall(cpuStall), .irqPending(irqPending),
		.sysResetReq(sysResetReq), .flashBrownout(flashBrownout), .hvError(hvError),
		.activateWriteEnable(activateWriteEnable), .targetSecured(targetSecured),
		.pageSelect(pageSelect), .nvmAddr(nvmAddr), .nvmWdata(nvmWdata), .nvmErase(nvmErase),
		.nvmProgram(nvmProgram), .nvmRdata(nvmRdata), .codeRdEn(codeRdEn),
		.codeRdAddr(codeRdAddr), .codeRdData(codeRdData));
	fpep_flash_model FLASH (.clk(clk), .nvmAddr(nvmAddr), .nvmWdata(nvmWdata),
		.nvmErase(nvmErase), .nvmProgram(nvmProgram), .nvmRdata(nvmRdata));

	// clock generation
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string msg);
		nChecks++;
		if (got !== exp) begin
			errorCnt++;
			$display("CHECK FAILED %0t %s got %h exp %h", $time, msg, got, exp);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		@(posedge clk);
		#1;
		sfrAddr = a;
		sfrWdata = v;
		sfrWrEn = 1'b1;
		@(posedge clk);
		#1 sfrWrEn = 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, output logic [7:0] v);
		@(posedge clk);
		#1;
		sfrAddr = a;
		sfrRdEn = 1'b1;
		@(posedge clk);
		#1 sfrRdEn = 1'b0;
		v = sfrRdata;
	endtask

	// code read: address taken, data two edges later
	task automatic cr(input logic [15:0] a, output logic [7:0] v);
		@(posedge clk);
		#1;
		codeRdAddr = a;
		codeRdEn = 1'b1;
		@(posedge clk);
		#1 codeRdEn = 1'b0;
		repeat (2) @(posedge clk);
		#1 v = codeRdData;
	endtask

	// start command, then look at the stall one edge later
	task automatic ep(input logic expStall);
		wr(fpep_pkg::ADDR_CMD_STATUS, fpep_pkg::CMD_ERASE_PROGRAM);
		@(posedge clk);
		#1 chk(16'(cpuStall), 16'(expStall), "stall after start");
	endtask

	task automatic wait_idle();
		n = 0;
		while (cpuStall === 1'b1 && n < 1000) begin
			n++;
			@(posedge clk);
			#1;
		end
		// a stall that never ends counts as a mismatch
		if (n >= 1000) begin
			errorCnt++;
			$display("CHECK FAILED %0t stall never released", $time);
		end
	endtask

	task automatic t_program();
		wr(fpep_pkg::ADDR_CMD_STATUS, fpep_pkg::CMD_LOAD);
		wr(fpep_pkg::ADDR_ADDR_LOW, 8'h25);
		wr(fpep_pkg::ADDR_WRITE_DATA, 8'h11);
		wr(fpep_pkg::ADDR_CMD_STATUS, fpep_pkg::CMD_LOAD);
		wr(fpep_pkg::ADDR_ADDR_HIGH, 8'h01);
		wr(fpep_pkg::ADDR_ADDR_LOW, 8'h2e);
		wr(fpep_pkg::ADDR_WRITE_DATA, 8'ha5);
		wr(fpep_pkg::ADDR_WRITE_DATA, 8'h3c);
		wr(fpep_pkg::ADDR_WRITE_DATA, 8'h0f);
		rd(fpep_pkg::ADDR_ADDR_LOW, d);
		chk(16'(d), 16'h0021, "index wrap");
		chk(16'(pageSelect), 16'h0012, "page select");
		ep(1'b1);
		wait_idle();
		// the first stalled cycle already passed inside ep
		chk(16'(n), 16'(2 * CYC - 1), "cycle length");
		rd(fpep_pkg::ADDR_CMD_STATUS, d);
		chk(16'(d), 16'h0000, "clean status");
		cr(16'h012e, d);
		chk(16'(d), 16'h00a5, "byte e");
		cr(16'h012f, d);
		chk(16'(d), 16'h003c, "byte f");
		cr(16'h0120, d);
		chk(16'(d), 16'h000f, "byte 0 after wrap");
		cr(16'h0125, d);
		chk(16'(d), 16'h0025 ^ 16'h005a, "cleared byte kept");
		cr(16'h0121, d);
		chk(16'(d), 16'h0021 ^ 16'h005a, "unloaded byte kept");
	endtask

	// abort of a running cycle: 0 interrupt, 1 hv fault, 2 reset request, 3 brownout
	// a brownout pulse needs two more edges through the synchroniser
	task automatic t_abort(input int kind, input logic [7:0] exp);
		ep(1'b1);
		repeat (10) @(posedge clk);
		#1;
		irqPending = (kind == 0);
		hvError = (kind == 1);
		sysResetReq = (kind == 2);
		flashBrownout = (kind == 3);
		@(posedge clk);
		#1;
		irqPending = 1'b0;
		hvError = 1'b0;
		sysResetReq = 1'b0;
		flashBrownout = 1'b0;
		repeat (2) @(posedge clk);
		#1 chk(16'(cpuStall), 16'h0000, "stall released");
		rd(fpep_pkg::ADDR_CMD_STATUS, d);
		chk(16'(d), 16'(exp), "abort status");
		wr(fpep_pkg::ADDR_CMD_STATUS, 8'h55);
		rd(fpep_pkg::ADDR_CMD_STATUS, d);
		chk(16'(d), 16'h0000, "command clears status");
	endtask

	// refused start: 0 secured page, 1 brownout, 2 write enable off
	task automatic t_refuse(input int kind, input logic [7:0] exp);
		targetSecured = (kind == 0);
		flashBrownout = (kind == 1);
		activateWriteEnable = (kind == 2);
		repeat (4) @(posedge clk);
		ep(1'b0);
		rd(fpep_pkg::ADDR_CMD_STATUS, d);
		chk(16'(d), 16'(exp), "refusal status");
		targetSecured = 1'b0;
		flashBrownout = 1'b0;
		repeat (4) @(posedge clk);
		#1;
	endtask

	task automatic t_write_enable();
		wr(fpep_pkg::ADDR_CMD_STATUS, fpep_pkg::CMD_SET_WE);
		wr(fpep_pkg::ADDR_WRITE_DATA, fpep_pkg::WE_KEY);
		ep(1'b1);
		wait_idle();
		wr(fpep_pkg::ADDR_CMD_STATUS, fpep_pkg::CMD_CLR_WE);
		wr(fpep_pkg::ADDR_WRITE_DATA, fpep_pkg::WE_KEY);
		ep(1'b0);
		rd(fpep_pkg::ADDR_CMD_STATUS, d);
		chk(16'(d), 16'(fpep_pkg::STATUS_SV), "write enable cleared");
		activateWriteEnable = 1'b0;
	endtask

	// reset in mid-cycle: no cycle survives and registers read their reset values
	task automatic t_reset();
		ep(1'b1);
		repeat (5) @(posedge clk);
		#1 rstn = 1'b0;
		@(posedge clk);
		#1 rstn = 1'b1;
		chk(16'(cpuStall), 16'h0000, "stall after reset");
		rd(fpep_pkg::ADDR_CMD_STATUS, d);
		chk(16'(d), 16'h0000, "status after mid reset");
		rd(fpep_pkg::ADDR_ADDR_LOW, d);
		chk(16'(d), 16'(fpep_pkg::ADDR_RESET), "address after mid reset");
		repeat (4) @(posedge clk);
		#1 chk(16'(cpuStall), 16'h0000, "no cycle restarts");
	endtask

	task automatic complete_run();
		if (errorCnt == 0 && nChecks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	// watchdog against a hung sequence
	initial begin
		#200us;
		errorCnt++;
		complete_run();
	end

	// main sequence
	initial begin
		{rstn, sfrWrEn, sfrRdEn, irqPending, sysResetReq, hvError, codeRdEn} = '0;
		{flashBrownout, activateWriteEnable, targetSecured} = '0;
		{sfrAddr, sfrWdata, codeRdAddr} = '0;
		errorCnt = 0;
		nChecks = 0;
		repeat (3) @(posedge clk);
		#1 rstn = 1'b1;
		rd(fpep_pkg::ADDR_CMD_STATUS, d);
		chk(16'(d), 16'h0000, "status after reset");
		rd(fpep_pkg::ADDR_ADDR_LOW, d);
		chk(16'(d), 16'(fpep_pkg::ADDR_RESET), "address after reset");
		t_program();
		t_abort(0, fpep_pkg::STATUS_OI | fpep_pkg::STATUS_HVA);
		t_abort(1, fpep_pkg::STATUS_HVE);
		t_abort(2, fpep_pkg::STATUS_OI);
		t_abort(3, fpep_pkg::STATUS_HVA);
		t_refuse(0, fpep_pkg::STATUS_SV);
		t_refuse(1, fpep_pkg::STATUS_HVA);
		t_refuse(2, fpep_pkg::STATUS_SV);
		activateWriteEnable = 1'b1;
		t_write_enable();
		t_reset();
		complete_run();
	end
endmodule // flash_page_erase_program_tb_top
`default_nettype wire
